// file: common/tcf_regs.vh
// register map, field codes, reset values and rule overview for the test-mode forcing block
`ifndef TCF_REGS_VH
`define TCF_REGS_VH
// Overview of operation
// - test mode only while function enabled and selected initiating operand is 1
// - input with force disabled reports its true terminal state, even in test mode
// - input forced open reports 0 throughout test mode
// - input forced closed reports 1 throughout test mode
// - inputs report normally once all input force settings are disabled
// - test-mode indicator is on while test mode is active
// - output with force disabled follows its control operand
// - output forced energize is closed throughout test mode
// - output forced de-energize is open throughout test mode
// - output forced freeze holds its state from before test mode
// - every reported status bit uses 1 for on and 0 for off
// - readable state of 32 virtual inputs
// - readable state of up to 64 virtual outputs from their equations
// - remote input reports point state, or its default while source device offline
// - track 16 remote devices; all-online flag drops if a required one is offline
// - sequence number is unsigned 32-bit and wraps to zero past its maximum
// - changeover outputs report on/off only; make outputs add voltage/current detectors

// byte offsets
`define TCF_CTRL      8'h00
`define TCF_STATUS    8'h04
`define TCF_INFORCE   8'h08
`define TCF_OUTFORCE  8'h0C
`define TCF_CIN       8'h10
`define TCF_COUT      8'h14
`define TCF_CVDET     8'h18
`define TCF_CIDET     8'h1C
`define TCF_VIN       8'h20
`define TCF_VOUTLO    8'h24
`define TCF_VOUTHI    8'h28
`define TCF_RIN       8'h2C
`define TCF_RINDEF    8'h30
`define TCF_RINSRC0   8'h34
`define TCF_RINSRC1   8'h38
`define TCF_RINSRC2   8'h3C
`define TCF_RINSRC3   8'h40
`define TCF_RDEVREQ   8'h44
`define TCF_RDEVON    8'h48
`define TCF_RDEVSEL   8'h4C
`define TCF_REMOTE_STATE_NUMBER     8'h50
`define TCF_REMOTE_SEQUENCE_NUMBER     8'h54

// field positions
`define TCF_CTRL_FUNC     0
`define TCF_CTRL_INITSEL  1
`define TCF_STATUS_TEST   0
`define TCF_STATUS_ALLON  1

// force codes
`define TCF_IN_DIS      2'h0
`define TCF_IN_OPEN     2'h1
`define TCF_IN_CLOSED   2'h2
`define TCF_OUT_DIS     2'h0
`define TCF_OUT_ENER    2'h1
`define TCF_OUT_DEEN    2'h2
`define TCF_OUT_FREEZE  2'h3

// reset values
`define TCF_CTRL_RST    32'h00000000
`define TCF_FORCE_RST   32'h00000000
`define TCF_RINDEF_RST  32'h00000000
`define TCF_RINSRC_RST  32'h00000000
`define TCF_RDEVREQ_RST 16'h0000
`define TCF_RDEVSEL_RST 4'h0

// bus responses
`define TCF_RESP_OKAY   2'h0
`define TCF_RESP_SLVERR 2'h2
`endif

// file: tb/tcf_far_side.sv
// remote peer model sending state and sequence counters
`timescale 1ns/1ns
module tcf_far_side
(
    input  wire        clk,
    input  wire        send,
    input  wire [3:0]  dev,
    input  wire        change,
    output reg         rxValid = 1'b0,
    output reg  [3:0]  rxDevice = 4'h0,
    output reg  [31:0] rxStateNum = 32'h00000000,
    output reg  [31:0] rxSeqNum = 32'h00000000
);
    // starts near the top so the wrap is reached in three messages
    reg [31:0] seqCnt = 32'hFFFFFFFE;
    reg [31:0] stCnt = 32'h00000000;

    always @(posedge clk)
    begin
        rxValid <= send;
        if (send)
        begin
            rxDevice <= dev;
            rxSeqNum <= seqCnt;
            rxStateNum <= stCnt + {31'h00000000, change};
            seqCnt <= seqCnt + 32'h00000001;
            stCnt <= stCnt + {31'h00000000, change};
        end
        else
        begin
            // stale payload toggles so it never passes for a fresh one
            rxDevice <= ~rxDevice;
            rxSeqNum <= ~rxSeqNum;
            rxStateNum <= ~rxStateNum;
        end
    end
endmodule

// file: tb/tcf_forcing_properties.sv
// assertion checker for the test-mode forcing top, attached by bind
`timescale 1ns/1ns
module tcf_properties
#(
    parameter NOUT = 16
)
(
    input wire            clk,
    input wire            sys_rst,
    input wire [NOUT-1:0] outOperand,
    input wire [NOUT-1:0] contactOut,
    input wire            testModeLed,
    input wire            allOnline,
    input wire [15:0]     remoteOnline,
    input wire            s_axi_awvalid,
    input wire            s_axi_awready,
    input wire            s_axi_wvalid,
    input wire            s_axi_wready,
    input wire            s_axi_bvalid,
    input wire            s_axi_bready,
    input wire [1:0]      s_axi_bresp,
    input wire            s_axi_arvalid,
    input wire            s_axi_arready,
    input wire            s_axi_rvalid,
    input wire            s_axi_rready,
    input wire [31:0]     s_axi_rdata
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    a_bresp_hold:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_rdata_hold:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    a_read_delay:
    assert property (s_axi_arvalid && s_axi_arready |=> !s_axi_arready ##1 s_axi_rvalid)
        else $error("read answer late");
    a_write_delay:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
                     |=> !s_axi_awready ##1 s_axi_bvalid)
        else $error("write answer late");
    a_ar_blocked:
    assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while one outstanding");
    a_aw_blocked:
    assert property ($rose(s_axi_bvalid) |-> !$past(s_axi_awready) && !$past(s_axi_wready))
        else $error("write accepted before response");
    a_follow_op:
    assert property (!testModeLed && !$past(sys_rst) |-> contactOut == $past(outOperand))
        else $error("output not following operand");
    a_allon_cause:
    assert property (!allOnline |-> $past(remoteOnline) != 16'hFFFF
                     || $past(remoteOnline, 2) != 16'hFFFF)
        else $error("all-online dropped with every device online");
    a_reset_vals:
    assert property ($past(sys_rst) |-> allOnline && !testModeLed
                     && contactOut == {NOUT{1'b0}} && !s_axi_bvalid && !s_axi_rvalid)
        else $error("wrong values after reset");
endmodule

bind tcf_forcing_top tcf_properties #(.NOUT(NOUT)) u_tcf_properties
(
    .clk, .sys_rst, .outOperand, .contactOut, .testModeLed, .allOnline, .remoteOnline,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
    .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata
);

// file: tb/test_mode_contact_forcing_tb_top.sv
// self-checking bench for the test-mode contact forcing block
`timescale 1ns/1ns
`include "tcf_regs.vh"
module test_mode_contact_forcing_tb_top;
    typedef struct packed {
        logic [31:0] inF;
        logic [31:0] outF;
        logic [15:0] term;
        logic [15:0] preOp;
        logic [15:0] newOp;
        logic [15:0] expRep;
        logic [15:0] expOut;
    } tcf_row_t;
    // codes per contact repeat disabled, open/energize, closed/de-energize, 3
    tcf_row_t    rows [3] = '{
        '{32'hE4E4E4E4, 32'hE4E4E4E4, 16'hFFFF, 16'hFFFF, 16'h0000, 16'hDDDD, 16'hAAAA},
        '{32'hE4E4E4E4, 32'hE4E4E4E4, 16'h0000, 16'h0000, 16'hFFFF, 16'h4444, 16'h3333},
        '{32'h00000000, 32'h00000000, 16'hA5A5, 16'h0000, 16'h5A5A, 16'hA5A5, 16'h5A5A}};
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [15:0] contactTerm = 16'h0000, outOperand = 16'h0000, vDetect = 16'h0000;
    logic [15:0] iDetect = 16'h0000, remoteOnline = 16'hFFFF;
    logic [31:0] virtualIn = 32'h00000000, remotePoint = 32'h00000000;
    logic [63:0] virtualOut = 64'h0000000000000000;
    logic        initOperand = 1'b0, send = 1'b0, change = 1'b0, rxValid;
    logic [3:0]  rxDevice;
    logic [31:0] rxStateNum, rxSeqNum, rdVal, s_axi_rdata;
    logic [15:0] contactOut, contactReport;
    logic        testModeLed, allOnline;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h00000000;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rdResp;
    int          nTests = 0, nFail = 0;

    always #20 clk = ~clk;

    tcf_forcing_top #(.MAKE_MASK(16'h00FF)) u_tcf_forcing_top
    (
        .clk, .sys_rst, .contactTerm, .initOperand, .outOperand, .vDetect, .iDetect,
        .virtualIn, .virtualOut, .remotePoint, .remoteOnline, .rxValid, .rxDevice,
        .rxStateNum, .rxSeqNum, .contactOut, .contactReport, .testModeLed, .allOnline,
        .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
        .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
        .s_axi_rdata, .s_axi_rresp
    );

    tcf_far_side u_tcf_far_side
    (
        .clk, .send, .dev(4'h3), .change, .rxValid, .rxDevice, .rxStateNum, .rxSeqNum
    );

    // ********
    // bus master and checking
    // ********
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        begin
            nTests++;
            if (got !== exp)
            begin
                nFail++;
                $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
            end
        end
    endtask

    // bready follows bvalid so the hold paths get exercised
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic pa = 1'b1, pw = 1'b1;
        begin
            @(posedge clk);
            s_axi_awvalid <= 1'b1;
            s_axi_awaddr <= a;
            s_axi_wvalid <= 1'b1;
            s_axi_wdata <= d;
            while (pa || pw)
            begin
                @(posedge clk);
                if (s_axi_awready)
                    pa = 1'b0;
                if (s_axi_wready)
                    pw = 1'b0;
                s_axi_awvalid <= pa;
                s_axi_wvalid <= pw;
            end
            do @(posedge clk); while (!s_axi_bvalid);
            s_axi_bready <= 1'b1;
            @(posedge clk);
            chk("bresp", 32'(s_axi_bresp), 32'(`TCF_RESP_OKAY));
            s_axi_bready <= 1'b0;
        end
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        begin
            @(posedge clk);
            s_axi_arvalid <= 1'b1;
            s_axi_araddr <= a;
            do @(posedge clk); while (!s_axi_arready);
            s_axi_arvalid <= 1'b0;
            do @(posedge clk); while (!s_axi_rvalid);
            s_axi_rready <= 1'b1;
            @(posedge clk);
            d = s_axi_rdata;
            r = s_axi_rresp;
            s_axi_rready <= 1'b0;
        end
    endtask

    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0]  r;
        begin
            rd(a, d, r);
            chk($sformatf("reg %h", a), d, e);
            chk("rresp", 32'(r), 32'(`TCF_RESP_OKAY));
        end
    endtask

    task automatic wrapUp;
        begin
            $display("comparisons %0d mismatches %0d", nTests, nFail);
            if (nFail == 0 && nTests > 0)
                $display("TEST PASSED");
            else
                $display("TEST FAILED");
            $finish;
        end
    endtask

    // ********
    // main sequence
    // ********
    initial
    begin
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        rc(`TCF_CTRL, `TCF_CTRL_RST);
        rc(`TCF_STATUS, 32'h00000002);
        rc(`TCF_INFORCE, `TCF_FORCE_RST);
        for (int i = 0; i < 3; i++)
        begin
            wr(`TCF_INFORCE, rows[i].inF);
            wr(`TCF_OUTFORCE, rows[i].outF);
            contactTerm <= rows[i].term;
            outOperand <= rows[i].preOp;
            repeat (8) @(posedge clk);
            wr(`TCF_CTRL, 32'h00000001);
            outOperand <= rows[i].newOp;
            repeat (8) @(posedge clk);
            chk("report", 32'(contactReport), 32'(rows[i].expRep));
            chk("out", 32'(contactOut), 32'(rows[i].expOut));
            chk("led on", 32'(testModeLed), 32'h00000001);
            rc(`TCF_COUT, 32'(rows[i].expOut));
            wr(`TCF_CTRL, 32'h00000000);
            repeat (3) @(posedge clk);
            chk("led off", 32'(testModeLed), 32'h00000000);
            chk("out free", 32'(contactOut), 32'(rows[i].newOp));
            chk("report free", 32'(contactReport), 32'(rows[i].term));
        end
        // test mode through the initiating operand
        wr(`TCF_CTRL, 32'h00000003);
        repeat (3) @(posedge clk);
        chk("led idle", 32'(testModeLed), 32'h00000000);
        initOperand <= 1'b1;
        repeat (3) @(posedge clk);
        rc(`TCF_STATUS, 32'h00000003);
        wr(`TCF_CTRL, 32'h00000002);
        repeat (3) @(posedge clk);
        chk("led disabled", 32'(testModeLed), 32'h00000000);
        rd(8'h80, rdVal, rdResp);
        chk("unmapped resp", 32'(rdResp), 32'(`TCF_RESP_SLVERR));
        chk("unmapped data", rdVal, 32'h00000000);
        virtualIn <= 32'h89ABCDEF;
        virtualOut <= 64'hFEDCBA9876543210;
        remotePoint <= 32'h0F0F00FF;
        vDetect <= 16'hFFFF;
        iDetect <= 16'h0F0F;
        repeat (8) @(posedge clk);
        rc(`TCF_VIN, 32'h89ABCDEF);
        rc(`TCF_VOUTLO, 32'h76543210);
        rc(`TCF_VOUTHI, 32'hFEDCBA98);
        rc(`TCF_RIN, 32'h0F0F00FF);
        rc(`TCF_CVDET, 32'h000000FF);
        rc(`TCF_CIDET, 32'h0000000F);
        // every remote input sources device 0 after reset
        wr(`TCF_RINDEF, 32'hFFFF0000);
        wr(`TCF_RDEVREQ, 32'h00000001);
        remoteOnline <= 16'hFFFE;
        repeat (4) @(posedge clk);
        rc(`TCF_RIN, 32'hFFFF0000);
        chk("all online", 32'(allOnline), 32'h00000000);
        remoteOnline <= 16'hFFFD;
        repeat (4) @(posedge clk);
        chk("not required", 32'(allOnline), 32'h00000001);
        rc(`TCF_RDEVON, 32'h0000FFFD);
        wr(`TCF_RINSRC0, 32'h00000001);
        rc(`TCF_RIN, 32'h0F0F00FE);
        wr(`TCF_RDEVSEL, 32'h00000003);
        for (int k = 0; k < 3; k++)
        begin
            send <= 1'b1;
            change <= (k == 0);
            @(posedge clk);
            send <= 1'b0;
            rc(`TCF_REMOTE_SEQUENCE_NUMBER, 32'(32'hFFFFFFFE + k));
            rc(`TCF_REMOTE_STATE_NUMBER, 32'h00000001);
        end
        sys_rst <= 1'b1;
        @(posedge clk);
        sys_rst <= 1'b0;
        rc(`TCF_RDEVREQ, 32'h00000000);
        wrapUp();
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        nFail++;
        wrapUp();
    end
endmodule

// file: verilog/tcf_forcing_top.v
// test-mode contact forcing and status reporting with an axi4-lite register slave
//
// Decided for this implementation: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`include "tcf_regs.vh"
module tcf_forcing_top
#(
    parameter NIN       = 16,
    parameter NOUT      = 16,
    parameter MAKE_MASK = 16'hFFFF
)
(
    input  wire            clk,
    input  wire            sys_rst,
    input  wire [NIN-1:0]  contactTerm,
    input  wire            initOperand,
    input  wire [NOUT-1:0] outOperand,
    input  wire [NOUT-1:0] vDetect,
    input  wire [NOUT-1:0] iDetect,
    input  wire [31:0]     virtualIn,
    input  wire [63:0]     virtualOut,
    input  wire [31:0]     remotePoint,
    input  wire [15:0]     remoteOnline,
    input  wire            rxValid,
    input  wire [3:0]      rxDevice,
    input  wire [31:0]     rxStateNum,
    input  wire [31:0]     rxSeqNum,
    output reg  [NOUT-1:0] contactOut,
    output reg  [NIN-1:0]  contactReport,
    output reg             testModeLed,
    output reg             allOnline,
    input  wire            s_axi_awvalid,
    output reg             s_axi_awready,
    input  wire [7:0]      s_axi_awaddr,
    input  wire            s_axi_wvalid,
    output reg             s_axi_wready,
    input  wire [31:0]     s_axi_wdata,
    input  wire [3:0]      s_axi_wstrb,
    output reg             s_axi_bvalid,
    input  wire            s_axi_bready,
    output reg  [1:0]      s_axi_bresp,
    input  wire            s_axi_arvalid,
    output reg             s_axi_arready,
    input  wire [7:0]      s_axi_araddr,
    output reg             s_axi_rvalid,
    input  wire            s_axi_rready,
    output reg  [31:0]     s_axi_rdata,
    output reg  [1:0]      s_axi_rresp
);
    // ****************************************************************
    // configuration registers
    // ****************************************************************
    reg  [31:0]       ctrl, inForce, outForce, rinDefault;
    reg  [31:0]       rinSrc [0:3];
    reg  [15:0]       rdevReq;
    reg  [3:0]        rdevSel;

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    // shared chain; a change counts once stages two and three agree
    localparam SW = NIN + 2 * NOUT;
    reg  [SW-1:0]     pinS1;
    reg  [SW-1:0]     pinS2;
    reg  [SW-1:0]     pinS3;
    reg  [SW-1:0]     pinTrue;
    wire [NIN-1:0]    cinTrue;
    wire [NOUT-1:0]   vTrue;
    wire [NOUT-1:0]   iTrue;

    assign cinTrue = pinTrue[NIN-1:0];
    assign vTrue   = pinTrue[NIN+NOUT-1:NIN];
    assign iTrue   = pinTrue[SW-1:NIN+NOUT];

    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            pinS1   <= {SW{1'b0}};
            pinS2   <= {SW{1'b0}};
            pinS3   <= {SW{1'b0}};
            pinTrue <= {SW{1'b0}};
        end
        else
        begin
            pinS1   <= {iDetect, vDetect, contactTerm};
            pinS2   <= pinS1;
            pinS3   <= pinS2;
            pinTrue <= (pinS2 & pinS3) | (pinTrue & (pinS2 ^ pinS3));
        end
    end

    // ****************************************************************
    // test mode and contact forcing
    // ****************************************************************
    reg  [NOUT-1:0]   frozen, next_frozen, next_out;
    reg  [NIN-1:0]    next_report;
    reg  [NOUT-1:0]   vReport, iReport;
    wire              next_testMode, entering;
    integer           k, kr, kc;

    // with the select clear the initiate setting is a constant on
    assign next_testMode = ctrl[`TCF_CTRL_FUNC] &
                           (~ctrl[`TCF_CTRL_INITSEL] | initOperand);
    assign entering      = next_testMode & ~testModeLed;

    always @*
    begin
        // capture the pre-test state on the same edge the mode starts,
        // so a frozen output never glitches to its operand
        next_frozen = entering ? contactOut : frozen;
        for (k = 0; k < NIN; k = k + 1)
        begin
            if (!next_testMode || inForce[2*k +: 2] == `TCF_IN_DIS)
                next_report[k] = cinTrue[k];
            else if (inForce[2*k +: 2] == `TCF_IN_CLOSED)
                next_report[k] = 1'b1;
            else if (inForce[2*k +: 2] == `TCF_IN_OPEN)
                next_report[k] = 1'b0;
            else
                next_report[k] = cinTrue[k];
        end
        for (k = 0; k < NOUT; k = k + 1)
        begin
            if (!next_testMode)
                next_out[k] = outOperand[k];
            else
            begin
                case (outForce[2*k +: 2])
                    `TCF_OUT_ENER:   next_out[k] = 1'b1;
                    `TCF_OUT_DEEN:   next_out[k] = 1'b0;
                    `TCF_OUT_FREEZE: next_out[k] = next_frozen[k];
                    default:         next_out[k] = outOperand[k];
                endcase
            end
        end
    end

    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            testModeLed   <= 1'b0;
            frozen        <= {NOUT{1'b0}};
            contactOut    <= {NOUT{1'b0}};
            contactReport <= {NIN{1'b0}};
            vReport       <= {NOUT{1'b0}};
            iReport       <= {NOUT{1'b0}};
        end
        else
        begin
            testModeLed   <= next_testMode;
            frozen        <= next_frozen;
            contactOut    <= next_out;
            contactReport <= next_report;
            // changeover contacts have no detectors to report
            vReport       <= vTrue & MAKE_MASK[NOUT-1:0];
            iReport       <= iTrue & MAKE_MASK[NOUT-1:0];
        end
    end

    // ****************************************************************
    // remote inputs and devices
    // ****************************************************************
    reg  [31:0]       rinState, next_rin;
    wire [63:0]       statWord;

    always @*
    begin
        for (kr = 0; kr < 32; kr = kr + 1)
        begin
            if (remoteOnline[rinSrc[kr / 8][4 * (kr % 8) +: 4]])
                next_rin[kr] = remotePoint[kr];
            else
                next_rin[kr] = rinDefault[kr];
        end
    end

    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            rinState  <= 32'h00000000;
            allOnline <= 1'b1;
        end
        else
        begin
            rinState  <= next_rin;
            allOnline <= &(remoteOnline | ~rdevReq);
        end
    end

    // received counters are stored as-is; wrap is the sender's business
    tcf_stat_mem #(.DEPTH(16), .AW(4), .W(64)) statMem
    (
        .clk    (clk),
        .wrEn   (rxValid),
        .wrAddr (rxDevice),
        .wrData ({rxSeqNum, rxStateNum}),
        .rdAddr (rdevSel),
        .rdData (statWord)
    );

    // ****************************************************************
    // axi4-lite slave
    // ****************************************************************
    reg               awHeld, wHeld, arPend, rdOk;
    reg  [7:0]        awAddrQ, arAddrQ;
    reg  [31:0]       wDataQ, rdMux;
    reg  [3:0]        wStrbQ;
    wire              awFire, wFire, arFire, doWrite;
    wire              next_awHeld, next_wHeld, next_bvalid, next_arPend, next_rvalid;
    wire              srcHit, wrMapped;
    wire [7:0]        srcOff;

    assign awFire      = s_axi_awvalid & s_axi_awready;
    assign wFire       = s_axi_wvalid & s_axi_wready;
    assign arFire      = s_axi_arvalid & s_axi_arready;
    assign doWrite     = awHeld & wHeld & ~s_axi_bvalid;
    assign next_awHeld = (awHeld | awFire) & ~doWrite;
    assign next_wHeld  = (wHeld | wFire) & ~doWrite;
    assign next_bvalid = doWrite | (s_axi_bvalid & ~s_axi_bready);
    assign next_arPend = arFire;
    assign next_rvalid = arPend | (s_axi_rvalid & ~s_axi_rready);
    assign srcOff      = awAddrQ - `TCF_RINSRC0;
    assign srcHit      = (awAddrQ >= `TCF_RINSRC0) && (awAddrQ <= `TCF_RINSRC3) &&
                         (awAddrQ[1:0] == 2'h0);
    assign wrMapped    = (awAddrQ[1:0] == 2'h0) && (awAddrQ <= `TCF_REMOTE_SEQUENCE_NUMBER);

    function [31:0] merge;
        input [31:0] old, din;
        input [3:0]  strb;
        integer      b;
        begin
            merge = old;
            for (b = 0; b < 4; b = b + 1)
            begin
                if (strb[b])
                    merge[8*b +: 8] = din[8*b +: 8];
            end
        end
    endfunction

    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            ctrl       <= `TCF_CTRL_RST;
            inForce    <= `TCF_FORCE_RST;
            outForce   <= `TCF_FORCE_RST;
            rinDefault <= `TCF_RINDEF_RST;
            for (kc = 0; kc < 4; kc = kc + 1)
                rinSrc[kc] <= `TCF_RINSRC_RST;
            rdevReq    <= `TCF_RDEVREQ_RST;
            rdevSel    <= `TCF_RDEVSEL_RST;
        end
        else if (doWrite)
        begin
            // read-only offsets take the write silently and answer okay
            if (srcHit)
                rinSrc[srcOff[3:2]] <= merge(rinSrc[srcOff[3:2]], wDataQ, wStrbQ);
            case (awAddrQ)
                `TCF_CTRL:     ctrl       <= merge(ctrl, wDataQ, wStrbQ);
                `TCF_INFORCE:  inForce    <= merge(inForce, wDataQ, wStrbQ);
                `TCF_OUTFORCE: outForce   <= merge(outForce, wDataQ, wStrbQ);
                `TCF_RINDEF:   rinDefault <= merge(rinDefault, wDataQ, wStrbQ);
                `TCF_RDEVREQ:
                begin
                    if (wStrbQ[0])
                        rdevReq[7:0] <= wDataQ[7:0];
                    if (wStrbQ[1])
                        rdevReq[15:8] <= wDataQ[15:8];
                end
                `TCF_RDEVSEL:
                begin
                    if (wStrbQ[0])
                        rdevSel <= wDataQ[3:0];
                end
                default:       ctrl       <= ctrl;
            endcase
        end
    end

    always @*
    begin
        rdOk  = 1'b1;
        rdMux = 32'h00000000;
        case (arAddrQ)
            `TCF_CTRL:     rdMux = ctrl;
            `TCF_STATUS:   rdMux = {30'h00000000, allOnline, testModeLed};
            `TCF_INFORCE:  rdMux = inForce;
            `TCF_OUTFORCE: rdMux = outForce;
            `TCF_CIN:      rdMux[NIN-1:0] = contactReport;
            `TCF_COUT:     rdMux[NOUT-1:0] = contactOut;
            `TCF_CVDET:    rdMux[NOUT-1:0] = vReport;
            `TCF_CIDET:    rdMux[NOUT-1:0] = iReport;
            `TCF_VIN:      rdMux = virtualIn;
            `TCF_VOUTLO:   rdMux = virtualOut[31:0];
            `TCF_VOUTHI:   rdMux = virtualOut[63:32];
            `TCF_RIN:      rdMux = rinState;
            `TCF_RINDEF:   rdMux = rinDefault;
            `TCF_RINSRC0:  rdMux = rinSrc[0];
            `TCF_RINSRC1:  rdMux = rinSrc[1];
            `TCF_RINSRC2:  rdMux = rinSrc[2];
            `TCF_RINSRC3:  rdMux = rinSrc[3];
            `TCF_RDEVREQ:  rdMux[15:0] = rdevReq;
            `TCF_RDEVON:   rdMux[15:0] = remoteOnline;
            `TCF_RDEVSEL:  rdMux[3:0] = rdevSel;
            `TCF_REMOTE_STATE_NUMBER:    rdMux = statWord[31:0];
            `TCF_REMOTE_SEQUENCE_NUMBER:    rdMux = statWord[63:32];
            default:       rdOk = 1'b0;
        endcase
    end

    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            awHeld        <= 1'b0;
            wHeld         <= 1'b0;
            awAddrQ       <= 8'h00;
            wDataQ        <= 32'h00000000;
            wStrbQ        <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `TCF_RESP_OKAY;
            arPend        <= 1'b0;
            arAddrQ       <= 8'h00;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `TCF_RESP_OKAY;
        end
        else
        begin
            awHeld        <= next_awHeld;
            wHeld         <= next_wHeld;
            s_axi_awready <= ~next_awHeld;
            s_axi_wready  <= ~next_wHeld;
            if (awFire)
                awAddrQ <= s_axi_awaddr;
            if (wFire)
            begin
                wDataQ <= s_axi_wdata;
                wStrbQ <= s_axi_wstrb;
            end
            s_axi_bvalid  <= next_bvalid;
            if (doWrite)
                s_axi_bresp <= wrMapped ? `TCF_RESP_OKAY : `TCF_RESP_SLVERR;
            arPend        <= next_arPend;
            s_axi_arready <= ~next_arPend & ~next_rvalid;
            if (arFire)
                arAddrQ <= s_axi_araddr;
            s_axi_rvalid  <= next_rvalid;
            if (arPend)
            begin
                s_axi_rdata <= rdMux;
                s_axi_rresp <= rdOk ? `TCF_RESP_OKAY : `TCF_RESP_SLVERR;
            end
        end
    end
endmodule

// file: verilog/tcf_stat_mem.v
// per-device store of the last received state and sequence numbers
`timescale 1ns/1ns
module tcf_stat_mem
#(
    parameter DEPTH = 16,
    parameter AW    = 4,
    parameter W     = 64
)
(
    input  wire          clk,
    input  wire          wrEn,
    input  wire [AW-1:0] wrAddr,
    input  wire [W-1:0]  wrData,
    input  wire [AW-1:0] rdAddr,
    output reg  [W-1:0]  rdData
);
    // no reset on the array: a device never heard from reads as undefined
    reg [W-1:0] mem [0:DEPTH-1];

    always @(posedge clk)
    begin
        if (wrEn)
        begin
            mem[wrAddr] <= wrData;
        end
        rdData <= mem[rdAddr];
    end
endmodule
